// ---- rtl/sup_nv_if.sv ----
interface sup_nv_if;
  import sup_pkg::*;
  logic wr_en;
  sup_wdt_sel_t wr_sel;
  sup_wdt_sel_t rd_sel;

  modport owner (output wr_en, output wr_sel, input rd_sel);
  modport store (input wr_en, input wr_sel, output rd_sel);
endinterface

// ---- rtl/sup_nv_store.sv ----
module sup_nv_store
  import sup_pkg::*;
(
  input wire logic clock_i,
  sup_nv_if.store nv
);
  // Cell is never touched by the system reset, so the choice outlives it
  sup_wdt_sel_t sel_r = WDT_SEL_DEFAULT;

  // Only a deliberate program strobe changes the stored interval
  always_ff @(posedge clock_i) begin
    if (nv.wr_en) begin
      sel_r <= nv.wr_sel;
    end
  end

  assign nv.rd_sel = sel_r;
endmodule

// ---- rtl/sup_pkg.sv ----
package sup_pkg;
  // Timebase
  localparam int CLK_HZ = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CNT_W = 28;

  // Power-up hold periods in ms (0.05 s, 0.2 s, 0.4 s, 0.8 s)
  localparam int PU_HOLD_MS_0 = 50;
  localparam int PU_HOLD_MS_1 = 200;
  localparam int PU_HOLD_MS_2 = 400;
  localparam int PU_HOLD_MS_3 = 800;

  // Watchdog intervals in ms (25 ms, 200 ms, 1.4 s)
  localparam int WDT_MS_0 = 25;
  localparam int WDT_MS_1 = 200;
  localparam int WDT_MS_2 = 1400;

  // Manual reset debounce time in ms
  localparam int DEBOUNCE_MS = 10;

  // Watchdog interval codes held in the nonvolatile cell
  typedef enum logic [1:0] {
    SUP_WDT_25MS   = 2'b00,
    SUP_WDT_200MS  = 2'b01,
    SUP_WDT_1400MS = 2'b10,
    SUP_WDT_OFF    = 2'b11
  } sup_wdt_sel_t;

  // Value the nonvolatile cell holds before it is ever programmed
  localparam sup_wdt_sel_t WDT_SEL_DEFAULT = SUP_WDT_200MS;

  // System reset sequencer states
  typedef enum logic [1:0] {
    SUP_RST_CAUSE = 2'b00,
    SUP_RST_HOLD  = 2'b01,
    SUP_RST_RUN   = 2'b10
  } sup_rst_state_t;

  // Synchroniser bit positions and their reset levels
  localparam int SYN_CORE = 0;
  localparam int SYN_RAIL2 = 1;
  localparam int SYN_MR = 2;
  localparam int SYN_SCL = 3;
  localparam int SYN_SDA = 4;
  localparam int SYN_W = 5;
  localparam logic [4:0] SYN_RESET = 5'h1c;
endpackage

// ---- rtl/sup_supervisor.sv ----
// Summary of operation
// - Power-up holds system reset for hold period.
// - Hold period selectable: 0.05, 0.2, 0.4, 0.8 s.
// - Core supply low asserts reset, then hold.
// - Watchdog output asserts if not restarted in time.
// - Watchdog interval 25 ms, 200 ms, 1.4 s, off.
// - Watchdog interval kept across power cycles.
// - Second-rail fail output follows sense three cycles later, no hold.
// - Early low output follows core supply comparator.
// - Manual reset input debounced internally.
// - Manual reset holds reset, then full hold period.
// - SDA fall with SCL high, SCL fall, then stop, restarts.
// - Reset output open-drain low or driven high.
module sup_supervisor
  import sup_pkg::*;
#(
  parameter bit RESET_ACTIVE_HIGH = 1'b0,
  parameter int PU_HOLD_CYC_0 = PU_HOLD_MS_0 * CYC_PER_MS,
  parameter int PU_HOLD_CYC_1 = PU_HOLD_MS_1 * CYC_PER_MS,
  parameter int PU_HOLD_CYC_2 = PU_HOLD_MS_2 * CYC_PER_MS,
  parameter int PU_HOLD_CYC_3 = PU_HOLD_MS_3 * CYC_PER_MS,
  parameter int WDT_CYC_0 = WDT_MS_0 * CYC_PER_MS,
  parameter int WDT_CYC_1 = WDT_MS_1 * CYC_PER_MS,
  parameter int WDT_CYC_2 = WDT_MS_2 * CYC_PER_MS,
  parameter int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS
)
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic core_supply_ok_i,
  input wire logic second_rail_sense_i,
  input wire logic manual_reset_in_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [1:0] hold_sel_i,
  input wire logic wdt_prog_i,
  input wire logic [1:0] wdt_prog_sel_i,
  output logic sys_reset_out_o,
  output logic sys_reset_oe_o,
  output logic second_rail_fail_n_o,
  output logic second_rail_fail_oe_o,
  output logic early_supply_low_n_o,
  output logic watchdog_expired_out_n_o,
  output logic watchdog_expired_out_oe_o
);
  localparam int CNT_MAX = 2 ** CNT_W - 1;

  // Refuse periods the counters cannot hold
  if (PU_HOLD_CYC_0 < 1 || PU_HOLD_CYC_1 < 1 || PU_HOLD_CYC_2 < 1 || PU_HOLD_CYC_3 < 1 ||
      WDT_CYC_0 < 1 || WDT_CYC_1 < 1 || WDT_CYC_2 < 1 || DEBOUNCE_CYC < 1) begin : g_chk_lo
    $error("sup_supervisor: every period must be at least one cycle");
  end
  if (PU_HOLD_CYC_0 > CNT_MAX || PU_HOLD_CYC_1 > CNT_MAX || PU_HOLD_CYC_2 > CNT_MAX ||
      PU_HOLD_CYC_3 > CNT_MAX || WDT_CYC_0 > CNT_MAX || WDT_CYC_1 > CNT_MAX ||
      WDT_CYC_2 > CNT_MAX || DEBOUNCE_CYC > CNT_MAX) begin : g_chk_hi
    $error("sup_supervisor: a period exceeds the counter width");
  end

  // Two-flop synchronisers for comparator results and pins
  logic [SYN_W-1:0] syn_raw;
  logic [SYN_W-1:0] syn_meta_r;
  logic [SYN_W-1:0] syn_r;
  assign syn_raw = {sda_i, scl_i, manual_reset_in_n_i, second_rail_sense_i, core_supply_ok_i};

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      syn_meta_r <= SYN_RESET;
      syn_r <= SYN_RESET;
    end else begin
      syn_meta_r <= syn_raw;
      syn_r <= syn_meta_r;
    end
  end

  logic core_ok;
  logic rail2_ok;
  logic mr_s;
  logic scl_s;
  logic sda_s;
  assign core_ok = syn_r[SYN_CORE];
  assign rail2_ok = syn_r[SYN_RAIL2];
  assign mr_s = syn_r[SYN_MR];
  assign scl_s = syn_r[SYN_SCL];
  assign sda_s = syn_r[SYN_SDA];

  // Manual reset debounce: a new level must stand for the whole debounce time
  logic mr_db_r;
  logic [CNT_W-1:0] db_cnt_r;
  logic db_done;
  assign db_done = (db_cnt_r == CNT_W'(DEBOUNCE_CYC - 1));

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mr_db_r <= 1'b1;
      db_cnt_r <= '0;
    end else if (mr_s == mr_db_r) begin
      db_cnt_r <= '0;
    end else if (db_done) begin
      mr_db_r <= mr_s;
      db_cnt_r <= '0;
    end else begin
      db_cnt_r <= db_cnt_r + CNT_W'(1);
    end
  end

  // Hold period selection
  logic [CNT_W-1:0] hold_len;
  assign hold_len = (hold_sel_i == 2'h0) ? CNT_W'(PU_HOLD_CYC_0) :
                    (hold_sel_i == 2'h1) ? CNT_W'(PU_HOLD_CYC_1) :
                    (hold_sel_i == 2'h2) ? CNT_W'(PU_HOLD_CYC_2) :
                    CNT_W'(PU_HOLD_CYC_3);

  // Reset sequencer: any cause holds reset, then a full hold period runs
  sup_rst_state_t rst_state_r;
  sup_rst_state_t rst_state_nxt;
  logic [CNT_W-1:0] hold_cnt_r;
  logic [CNT_W-1:0] hold_cnt_nxt;
  logic rst_cause;
  assign rst_cause = !core_ok || !mr_db_r;

  always_comb begin
    rst_state_nxt = rst_state_r;
    hold_cnt_nxt = hold_cnt_r;
    unique case (rst_state_r)
      SUP_RST_CAUSE: begin
        hold_cnt_nxt = '0;
        if (!rst_cause) begin
          rst_state_nxt = SUP_RST_HOLD;
        end
      end
      SUP_RST_HOLD: begin
        if (rst_cause) begin
          rst_state_nxt = SUP_RST_CAUSE;
        end else if (hold_cnt_r >= hold_len - CNT_W'(1)) begin
          rst_state_nxt = SUP_RST_RUN;
        end else begin
          hold_cnt_nxt = hold_cnt_r + CNT_W'(1);
        end
      end
      SUP_RST_RUN: begin
        if (rst_cause) begin
          rst_state_nxt = SUP_RST_CAUSE;
        end
      end
      default: begin
        rst_state_nxt = SUP_RST_CAUSE;
      end
    endcase
  end

  // Power-up enters the cause state, so the first release needs a hold period
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rst_state_r <= SUP_RST_CAUSE;
      hold_cnt_r <= '0;
    end else begin
      rst_state_r <= rst_state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  logic sys_rst_on;
  assign sys_rst_on = (rst_state_nxt != SUP_RST_RUN);

  // Nonvolatile watchdog interval cell
  sup_nv_if nv_bus ();
  assign nv_bus.wr_en = wdt_prog_i;
  assign nv_bus.wr_sel = sup_wdt_sel_t'(wdt_prog_sel_i);

  sup_nv_store u_nv (
    .clock_i(clock_i),
    .nv(nv_bus.store)
  );

  // Restart sequence: SDA falls with SCL high, SCL falls, then stop
  logic scl_d_r;
  logic sda_d_r;
  logic seq_a_r;
  logic seq_b_r;
  logic sda_fall;
  logic scl_fall;
  logic stop_cond;
  logic wdt_kick;
  assign sda_fall = sda_d_r && !sda_s;
  assign scl_fall = scl_d_r && !scl_s;
  assign stop_cond = !sda_d_r && sda_s && scl_s;
  assign wdt_kick = stop_cond && seq_b_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      seq_a_r <= 1'b0;
      seq_b_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (stop_cond) begin
        seq_a_r <= 1'b0;
        seq_b_r <= 1'b0;
      end else if (sda_fall && scl_d_r) begin
        seq_a_r <= 1'b1;
        seq_b_r <= scl_fall;
      end else if (seq_a_r && scl_fall) begin
        seq_b_r <= 1'b1;
      end
    end
  end

  // Watchdog interval selection; off code stops the timer
  logic [CNT_W-1:0] wdt_len;
  logic wdt_run;
  assign wdt_len = (nv_bus.rd_sel == SUP_WDT_25MS) ? CNT_W'(WDT_CYC_0) :
                   (nv_bus.rd_sel == SUP_WDT_200MS) ? CNT_W'(WDT_CYC_1) :
                   CNT_W'(WDT_CYC_2);
  assign wdt_run = (nv_bus.rd_sel != SUP_WDT_OFF) && (rst_state_r == SUP_RST_RUN);

  // Watchdog counter; expiry stands until a restart sequence, a system reset or the off code
  logic [CNT_W-1:0] wdt_cnt_r;
  logic wdt_exp_r;

  always_ff @(posedge clock_i) begin
    if (reset_i || !wdt_run || wdt_kick) begin
      wdt_cnt_r <= '0;
      wdt_exp_r <= 1'b0;
    end else if (wdt_cnt_r >= wdt_len - CNT_W'(1)) begin
      wdt_exp_r <= 1'b1;
    end else begin
      wdt_cnt_r <= wdt_cnt_r + CNT_W'(1);
    end
  end

  // Registered pins; open-drain pins pull low only while their oe is high
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sys_reset_out_o <= RESET_ACTIVE_HIGH;
      sys_reset_oe_o <= 1'b1;
      second_rail_fail_n_o <= 1'b0;
      second_rail_fail_oe_o <= 1'b1;
      early_supply_low_n_o <= 1'b0;
      watchdog_expired_out_n_o <= 1'b1;
      watchdog_expired_out_oe_o <= 1'b0;
    end else begin
      sys_reset_out_o <= RESET_ACTIVE_HIGH ? sys_rst_on : 1'b0;
      sys_reset_oe_o <= RESET_ACTIVE_HIGH ? 1'b1 : sys_rst_on;
      second_rail_fail_n_o <= rail2_ok;
      second_rail_fail_oe_o <= !rail2_ok;
      early_supply_low_n_o <= core_ok;
      watchdog_expired_out_n_o <= !wdt_exp_r;
      watchdog_expired_out_oe_o <= wdt_exp_r;
    end
  end
endmodule

// ---- verification/sup_checker.sv ----
module sup_checker #(
  parameter bit RESET_ACTIVE_HIGH = 1'b1,
  parameter int PU_HOLD_CYC_0 = 20,
  parameter int WDT_CYC_0 = 100,
  parameter int DEBOUNCE_CYC = 5
)
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic core_supply_ok_i,
  input wire logic second_rail_sense_i,
  input wire logic manual_reset_in_n_i,
  input wire logic sys_reset_out_o,
  input wire logic sys_reset_oe_o,
  input wire logic second_rail_fail_n_o,
  input wire logic second_rail_fail_oe_o,
  input wire logic early_supply_low_n_o,
  input wire logic watchdog_expired_out_n_o,
  input wire logic watchdog_expired_out_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Reset activity seen the same way for both output variants
  wire rst_act = RESET_ACTIVE_HIGH ? sys_reset_out_o : sys_reset_oe_o;
  logic [2:0] age_r;
  int rst_len_r;
  int run_len_r;
  int mr_low_r;
  // Span counters; age masks stale synchroniser contents after reset
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      age_r <= 3'h0;
      rst_len_r <= 0;
      run_len_r <= 0;
      mr_low_r <= 0;
    end else begin
      age_r <= (age_r == 3'h7) ? age_r : age_r + 3'h1;
      rst_len_r <= rst_act ? rst_len_r + 1 : 0;
      run_len_r <= rst_act ? 0 : run_len_r + 1;
      mr_low_r <= manual_reset_in_n_i ? 0 : mr_low_r + 1;
    end
  end
  // Three samples of active reset in a row
  sequence s_rst3;
    rst_act ##1 rst_act ##1 rst_act;
  endsequence
  AST_EARLY: assert property (age_r == 3'h7 |-> early_supply_low_n_o == $past(core_supply_ok_i, 3))
    else $error("early low output does not follow core level");
  AST_RAIL: assert property (age_r == 3'h7 |-> second_rail_fail_oe_o == !second_rail_fail_n_o
    && second_rail_fail_n_o == $past(second_rail_sense_i, 3))
    else $error("second rail output does not follow sense");
  AST_CORE: assert property (age_r == 3'h7 && !$past(core_supply_ok_i, 4) |-> rst_act)
    else $error("core low without system reset");
  AST_HOLD: assert property ($fell(rst_act) |-> $past(rst_len_r) >= PU_HOLD_CYC_0)
    else $error("system reset released too early");
  AST_POL: assert property (RESET_ACTIVE_HIGH ? sys_reset_oe_o : !sys_reset_out_o)
    else $error("reset pin polarity wrong");
  AST_WDOE: assert property (watchdog_expired_out_n_o != watchdog_expired_out_oe_o)
    else $error("watchdog pin level and enable disagree");
  AST_WDQ: assert property ($rose(watchdog_expired_out_oe_o) |-> $past(run_len_r) >= WDT_CYC_0)
    else $error("watchdog expired too soon");
  AST_WDH: assert property (s_rst3 |-> !watchdog_expired_out_oe_o)
    else $error("watchdog expired during system reset");
  AST_MR: assert property (mr_low_r > DEBOUNCE_CYC + 4 |-> rst_act)
    else $error("manual reset held without system reset");
endmodule

bind sup_supervisor sup_checker #(.RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH),
  .PU_HOLD_CYC_0(PU_HOLD_CYC_0), .WDT_CYC_0(WDT_CYC_0), .DEBOUNCE_CYC(DEBOUNCE_CYC))
  sup_checker_inst (.clock_i(clock_i), .reset_i(reset_i), .core_supply_ok_i(core_supply_ok_i),
  .second_rail_sense_i(second_rail_sense_i), .manual_reset_in_n_i(manual_reset_in_n_i),
  .sys_reset_out_o(sys_reset_out_o), .sys_reset_oe_o(sys_reset_oe_o),
  .second_rail_fail_n_o(second_rail_fail_n_o), .second_rail_fail_oe_o(second_rail_fail_oe_o),
  .early_supply_low_n_o(early_supply_low_n_o), .watchdog_expired_out_n_o(watchdog_expired_out_n_o),
  .watchdog_expired_out_oe_o(watchdog_expired_out_oe_o));

// ---- verification/sup_host_model.sv ----
module sup_host_model (
  input wire logic clock_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Both lines idle at their pulled-up level
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One step of the lines, moved just after an edge
  task automatic step(input logic c, input logic d, input int gap);
    repeat (gap) @(posedge clock_i);
    #1;
    scl_o = c;
    sda_o = d;
  endtask
  // Restart: data falls with clock high, clock falls, then a stop; gap sets the pace
  task automatic kick(input int gap);
    step(1'b1, 1'b0, gap);
    step(1'b0, 1'b0, gap);
    step(1'b1, 1'b0, gap);
    step(1'b1, 1'b1, gap);
  endtask
endmodule

// ---- verification/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i;
  logic reset_i = 1'b1;
  logic core_ok = 1'b1;
  logic rail = 1'b1;
  logic mr_n = 1'b1;
  logic [1:0] hold_sel = 2'h0;
  logic prog = 1'b0;
  logic [1:0] prog_sel = 2'h0;
  logic scl, sda, rst_out, rst_oe, rail_n, rail_oe, early_n, wdo_n, wdo_oe;
  logic od_rst_out, od_rst_oe;
  int failures = 0;
  int num_checks = 0;
  int n;
  // Shortened periods so every hold and timeout fits a short run
  localparam int HOLD_C[4] = '{20, 40, 60, 80};
  localparam int WDT_C[3] = '{100, 200, 300};
  localparam int DB_C = 5;
  // Select code, hold cycles, watchdog cycles (0 means off)
  int rows[4][3] = '{'{0, HOLD_C[0], WDT_C[0]}, '{1, HOLD_C[1], WDT_C[1]},
    '{2, HOLD_C[2], WDT_C[2]}, '{3, HOLD_C[3], 0}};
  sup_supervisor #(.RESET_ACTIVE_HIGH(1'b1), .PU_HOLD_CYC_0(HOLD_C[0]),
    .PU_HOLD_CYC_1(HOLD_C[1]), .PU_HOLD_CYC_2(HOLD_C[2]), .PU_HOLD_CYC_3(HOLD_C[3]),
    .WDT_CYC_0(WDT_C[0]), .WDT_CYC_1(WDT_C[1]), .WDT_CYC_2(WDT_C[2]),
    .DEBOUNCE_CYC(DB_C)) sup_supervisor_inst (.clock_i(clock_i),
    .reset_i(reset_i), .core_supply_ok_i(core_ok), .second_rail_sense_i(rail),
    .manual_reset_in_n_i(mr_n), .scl_i(scl), .sda_i(sda), .hold_sel_i(hold_sel),
    .wdt_prog_i(prog), .wdt_prog_sel_i(prog_sel), .sys_reset_out_o(rst_out),
    .sys_reset_oe_o(rst_oe), .second_rail_fail_n_o(rail_n), .second_rail_fail_oe_o(rail_oe),
    .early_supply_low_n_o(early_n), .watchdog_expired_out_n_o(wdo_n),
    .watchdog_expired_out_oe_o(wdo_oe));
  sup_host_model sup_host_model_inst (.clock_i(clock_i), .scl_o(scl), .sda_o(sda));
  // Open-drain variant on the same inputs; its reset pin must track the other one
  if (1'b1) begin : g_open_drain
    sup_supervisor #(.RESET_ACTIVE_HIGH(1'b0), .PU_HOLD_CYC_0(HOLD_C[0]),
      .PU_HOLD_CYC_1(HOLD_C[1]), .PU_HOLD_CYC_2(HOLD_C[2]), .PU_HOLD_CYC_3(HOLD_C[3]),
      .WDT_CYC_0(WDT_C[0]), .WDT_CYC_1(WDT_C[1]), .WDT_CYC_2(WDT_C[2]),
      .DEBOUNCE_CYC(DB_C)) sup_supervisor_inst (.clock_i(clock_i), .reset_i(reset_i),
      .core_supply_ok_i(core_ok), .second_rail_sense_i(rail), .manual_reset_in_n_i(mr_n),
      .scl_i(scl), .sda_i(sda), .hold_sel_i(hold_sel), .wdt_prog_i(prog),
      .wdt_prog_sel_i(prog_sel), .sys_reset_out_o(od_rst_out), .sys_reset_oe_o(od_rst_oe),
      .second_rail_fail_n_o(), .second_rail_fail_oe_o(), .early_supply_low_n_o(),
      .watchdog_expired_out_n_o(), .watchdog_expired_out_oe_o());
  end
  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Inputs move 1 ns after the edge so no race with the design
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task automatic power_up();
    reset_i = 1'b1;
    tick(3);
    reset_i = 1'b0;
  endtask
  // Bounded wait on the reset pin or the watchdog pin; n saturates at 2000
  task automatic count_until(input bit on_wdo, input logic lvl);
    n = 0;
    while ((on_wdo ? wdo_oe : rst_out) !== lvl && n < 2000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic store_interval(input logic [1:0] sel);
    prog_sel = sel;
    prog = 1'b1;
    tick(1);
    prog = 1'b0;
  endtask
  // Table cases first, then the awkward ones by hand
  initial begin
    power_up();
    tick(1);
    foreach (rows[i]) begin
      hold_sel = 2'(rows[i][0]);
      store_interval(2'(rows[i][0]));
      power_up();
      count_until(1'b0, 1'b0);
      check((n - rows[i][1]) inside {[0:6]}, 1'b1);
      check({od_rst_oe, od_rst_out}, 2'b00);
      count_until(1'b1, 1'b1);
      check(rows[i][2] == 0 ? n == 2000 : (n - rows[i][2]) inside {[0:6]}, 1'b1);
      $display("row %0d done", i);
    end
    hold_sel = 2'h0;
    core_ok = 1'b0;
    rail = 1'b0;
    tick(5);
    check({early_n, rst_out, rail_n, rail_oe}, 4'h5);
    check({od_rst_oe, od_rst_out}, 2'b10);
    rail = 1'b1;
    core_ok = 1'b1;
    tick(12);
    check({rail_n, rail_oe, early_n, rst_out}, 4'hb);
    core_ok = 1'b0;
    tick(1);
    core_ok = 1'b1;
    count_until(1'b0, 1'b0);
    check((n - HOLD_C[0]) inside {[0:6]}, 1'b1);
    $display("supply test done");
    mr_n = 1'b0;
    tick(3);
    mr_n = 1'b1;
    tick(12);
    check(rst_out, 1'b0);
    mr_n = 1'b0;
    tick(30);
    check(rst_out, 1'b1);
    mr_n = 1'b1;
    count_until(1'b0, 1'b0);
    check((n - HOLD_C[0] - DB_C) inside {[0:8]}, 1'b1);
    $display("manual reset test done");
    store_interval(2'h0);
    power_up();
    count_until(1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      tick(50);
      sup_host_model_inst.kick(k % 2 ? 8 : 1);
      check(wdo_oe, 1'b0);
    end
    count_until(1'b1, 1'b1);
    check({wdo_n, (n - WDT_C[0]) inside {[-10:6]}}, 2'b01);
    sup_host_model_inst.kick(1);
    tick(5);
    check(wdo_oe, 1'b0);
    $display("watchdog test done");
    report_and_stop();
  end
  // Cuts a hang short; the run needs about 3.4k cycles
  initial begin
    #300000;
    failures++;
    report_and_stop();
  end
endmodule
